// ### shared/tmo_params.svh
/*
 * Constants of the 8-bit timer, its shared prescaler and the quarter-phase counter.
 * Assumes inclusion by bare name from design files.
 */
`ifndef TMO_PARAMS_SVH
`define TMO_PARAMS_SVH

`define TMO_CNT_W 8
`define TMO_PRE_W 8
`define TMO_RATE_W 3
`define TMO_CNT_ZERO 8'h00
`define TMO_CNT_MAX 8'hFF
`define TMO_PRE_ZERO 8'h00
`define TMO_ASSIGN_TIMER 1'b0
`define TMO_PHASE_ZERO 2'h0
`define TMO_PHASE_Q2 2'h1
`define TMO_PHASE_Q4 2'h3
`define TMO_PHASE_ONE 2'h1

`endif

// ### shared/tmo_pkg.sv
/*
 * Types shared by the timer block.
 * Assumes nothing of its surroundings.
 */
package tmo_pkg;
    typedef enum logic {
        TMO_MODE_TIMER,
        TMO_MODE_COUNTER
    } tmo_mode_t;
endpackage

// ### shared/tmo_pre_if.sv
/*
 * Carrier between the timer top and its prescaler.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface tmo_pre_if;
    logic tick;
    logic clear;
    logic [2:0] rate;
    logic to_timer;
    logic pre_out;
    logic [7:0] pre_cnt;
    modport ctrl (output tick, output clear, output rate, output to_timer,
                  input pre_out, input pre_cnt);
    modport pre (input tick, input clear, input rate, input to_timer,
                 output pre_out, output pre_cnt);
endinterface

// ### core/tmo_prescaler.sv
/*
 * Shared ripple-style prescaler, modelled as an 8-bit counter.
 * Assumes tick is a one-cycle pulse on the core clock.
 */
`timescale 1ns/1ps
`include "tmo_params.svh"
module tmo_prescaler (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // control side
    tmo_pre_if.pre pre_if
);
    logic [`TMO_PRE_W-1:0] cnt_r;
    logic [`TMO_PRE_W-1:0] cnt_nxt;
    logic [`TMO_PRE_W-1:0] tap_mask;

    assign cnt_nxt = pre_if.clear ? `TMO_PRE_ZERO :
                     pre_if.tick ? cnt_r + 8'h01 : cnt_r;
    // bit n of the counter divides by 2^(n+1)
    assign tap_mask = 8'h01 << pre_if.rate;
    assign pre_if.pre_out = |(cnt_r & tap_mask);
    // count reaches no port of the top, so software cannot touch it
    assign pre_if.pre_cnt = cnt_r;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r <= `TMO_PRE_ZERO;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// ### core/tmo_timer.sv
/*
 * 8-bit timer/counter with shared prescaler and sticky overflow flag.
 * Assumes one core clock, four of whose cycles make an instruction cycle;
 * software accesses arrive as one-cycle strobes from the core.
 */
`timescale 1ns/1ps
`include "tmo_params.svh"
// Summary of operation
// - one prescaler, timer or watchdog, never both
// - assign select zero routes prescaler to timer
// - rate field picks ratio 1:2 to 1:256
// - watchdog assignment makes timer count 1:1
// - prescaler count has no register address
// - timer write clears prescaler when timer-assigned
// - watchdog clear resets prescaler when watchdog-assigned
// - wrap FFh to 00h raises overflow
// - flag sets on overflow regardless of enable
// - only software clears the overflow flag
// - enable bit gates flag to request
// - timer frozen in sleep, cannot wake
// - external edges synchronized before counting
// - sample prescaler output at Q2 and Q4
module tmo_timer (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // configuration
    input wire logic prescaler_assign_select_in,
    input wire logic [2:0] prescale_rate_select_in,
    input wire logic counter_mode_in,
    input wire logic edge_falling_in,
    input wire logic sleep_in,
    // software access
    input wire logic timer_write_in,
    input wire logic [7:0] timer_wdata_in,
    input wire logic flag_clear_in,
    input wire logic timer_overflow_irq_enable_in,
    input wire logic global_irq_enable_in,
    input wire logic watchdog_clear_instruction_in,
    // external count source
    input wire logic external_count_input_in,
    // watchdog feed
    input wire logic watchdog_tick_in,
    // status
    output logic [7:0] timer_count_value_out,
    output logic timer_overflow_flag_out,
    output logic timer_irq_out,
    output logic watchdog_pre_tick_out,
    output logic watchdog_clear_out
);
    tmo_pre_if pre_if ();
    tmo_pkg::tmo_mode_t mode;

    logic [2:0] ext_sync_r;
    logic ext_level_r;
    logic [1:0] phase_r;
    logic sample_r;
    logic pre_out_d_r;
    logic [`TMO_CNT_W-1:0] cnt_r;
    logic [`TMO_CNT_W-1:0] cnt_nxt;
    logic flag_r;
    logic flag_nxt;
    logic wdt_tick_d_r;

    wire to_timer = prescaler_assign_select_in == `TMO_ASSIGN_TIMER;
    wire ext_agree = ext_sync_r[1] == ext_sync_r[2];
    wire ext_stable = ext_agree ? ext_sync_r[2] : ext_level_r;
    wire ext_active = ext_stable ^ edge_falling_in;
    wire ext_rise = ext_active & ~(ext_level_r ^ edge_falling_in);
    wire instr_tick = phase_r == `TMO_PHASE_Q4;
    wire q_sample = (phase_r == `TMO_PHASE_Q2) | (phase_r == `TMO_PHASE_Q4);
    wire src_tick = (mode == tmo_pkg::TMO_MODE_COUNTER) ? ext_rise
                                                        : instr_tick;
    // frozen in sleep: timer and prescaler do not advance, so overflow cannot wake the core
    wire run = ~sleep_in;
    wire div_pulse = q_sample & sample_r & ~pre_out_d_r;
    wire inc = run & ~timer_write_in &
               (to_timer ? div_pulse : src_tick);
    wire wrap = inc & (cnt_r == `TMO_CNT_MAX);

    assign mode = counter_mode_in ? tmo_pkg::TMO_MODE_COUNTER
                                  : tmo_pkg::TMO_MODE_TIMER;
    // prescaler input is the timer source or the watchdog, not both
    assign pre_if.tick = run & (to_timer ? src_tick : watchdog_tick_in);
    assign pre_if.clear = (to_timer & timer_write_in) |
                          (~to_timer & watchdog_clear_instruction_in);
    assign pre_if.rate = prescale_rate_select_in;
    assign pre_if.to_timer = to_timer;
    assign cnt_nxt = timer_write_in ? timer_wdata_in :
                     inc ? cnt_r + 8'h01 : cnt_r;
    // set wins over a same-cycle clear; hardware never clears
    assign flag_nxt = wrap ? 1'b1 : (flag_clear_in ? 1'b0 : flag_r);
    assign timer_count_value_out = cnt_r;
    assign timer_overflow_flag_out = flag_r;
    assign timer_irq_out = flag_r & timer_overflow_irq_enable_in &
                           global_irq_enable_in;
    assign watchdog_pre_tick_out = ~to_timer & pre_if.pre_out &
                                   ~wdt_tick_d_r;
    assign watchdog_clear_out = watchdog_clear_instruction_in;

    tmo_prescaler u_pre (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .pre_if(pre_if)
    );

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ext_sync_r <= 3'h0;
            ext_level_r <= 1'b0;
        end else begin
            ext_sync_r <= {ext_sync_r[1:0], external_count_input_in};
            ext_level_r <= ext_stable;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase_r <= `TMO_PHASE_ZERO;
        end else begin
            phase_r <= phase_r + `TMO_PHASE_ONE;
        end
    end

    // prescaler output held between quarter-phase samples
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sample_r <= 1'b0;
            pre_out_d_r <= 1'b0;
        end else if (q_sample) begin
            sample_r <= pre_if.pre_out;
            pre_out_d_r <= sample_r;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r <= `TMO_CNT_ZERO;
            flag_r <= 1'b0;
            wdt_tick_d_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            flag_r <= flag_nxt;
            wdt_tick_d_r <= pre_if.pre_out;
        end
    end

    a_flag_set_wrap: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in) wrap |=> flag_r && cnt_r == `TMO_CNT_ZERO)
        else $error("overflow did not set flag");
    a_flag_sticky: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in) flag_r && !flag_clear_in |=> flag_r)
        else $error("flag dropped without software clear");
    a_flag_no_enable: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        wrap && !timer_overflow_irq_enable_in |=> flag_r)
        else $error("flag gated by enable");
    a_irq_gating: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in) timer_irq_out == (flag_r &&
        timer_overflow_irq_enable_in && global_irq_enable_in))
        else $error("request gating wrong");
    a_sleep_freeze: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        sleep_in && !timer_write_in |=> $stable(cnt_r))
        else $error("timer moved in sleep");
    a_write_clears_pre: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        timer_write_in && to_timer |=> pre_if.pre_cnt == `TMO_PRE_ZERO)
        else $error("timer write left prescaler");
    a_wdt_clear_pre: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in) watchdog_clear_instruction_in && !to_timer
        |=> pre_if.pre_cnt == `TMO_PRE_ZERO)
        else $error("watchdog clear left prescaler");
    a_one_to_one: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in) !to_timer && run && src_tick &&
        !timer_write_in |=> cnt_r == $past(cnt_r) + 8'h01)
        else $error("undivided count missed");
    a_pre_exclusive: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in) to_timer |-> !watchdog_pre_tick_out)
        else $error("prescaler served both");
    a_counts_at_q: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in) inc && to_timer |-> q_sample)
        else $error("divided count off quarter phase");
endmodule

// ### tb/tmo_ext_src.sv
/*
 * Model of the external count source feeding the timer's count pin.
 * Assumes the bench pulses go_in in the same step as it sets edges_in.
 */
`timescale 1ns/1ps
module tmo_ext_src (
    // clock and control
    input wire logic core_clk_in,
    input wire logic go_in,
    input wire logic [7:0] edges_in,
    // count pin
    output logic pin_out
);
    // pin idles low between bursts, as if pulled down
    initial pin_out = 1'b0;
    // slow edges, well apart from the core clock
    always @(posedge go_in) begin
        repeat (edges_in) begin
            repeat (10) @(posedge core_clk_in);
            #3 pin_out = 1'b1;
            repeat (10) @(posedge core_clk_in);
            #3 pin_out = 1'b0;
        end
    end
endmodule

// ### tb/tb.sv
/*
 * Self-checking bench of the 8-bit timer with shared prescaler.
 * Assumes four core clocks make one instruction cycle.
 */
`timescale 1ns/1ps
module tb;
    logic core_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic asel = 1'b1, cmode = 1'b0, sleep = 1'b0, wr = 1'b0, fclr = 1'b0;
    logic ie = 1'b0, global_irq_enable = 1'b0, wclr = 1'b0, wtick = 1'b0, go = 1'b0;
    logic [2:0] rate = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] edges = 8'h00;
    logic [7:0] cnt;
    logic pin, flag, irq, wpre, wcout;
    int err_total = 0, checks_done = 0, n, k;
    tmo_ext_src u_tmo_ext_src (.core_clk_in(core_clk_in), .go_in(go),
        .edges_in(edges), .pin_out(pin));
    tmo_timer u_tmo_timer (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .prescaler_assign_select_in(asel), .prescale_rate_select_in(rate),
        .counter_mode_in(cmode), .edge_falling_in(1'b0), .sleep_in(sleep),
        .timer_write_in(wr), .timer_wdata_in(wdata), .flag_clear_in(fclr),
        .timer_overflow_irq_enable_in(ie), .global_irq_enable_in(global_irq_enable),
        .watchdog_clear_instruction_in(wclr), .external_count_input_in(pin),
        .watchdog_tick_in(wtick), .timer_count_value_out(cnt),
        .timer_overflow_flag_out(flag), .timer_irq_out(irq),
        .watchdog_pre_tick_out(wpre), .watchdog_clear_out(wcout));
    initial forever #5 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) if (wpre === 1'b1) k++;
    task automatic step(input int c);
        repeat (c) @(posedge core_clk_in);
        #1;
    endtask
    task automatic check(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic wait_change(output int c);
        logic [7:0] prev;
        prev = cnt;
        c = 0;
        while (cnt === prev && c < 3000) begin
            step(1);
            c++;
        end
    endtask
    task automatic write(input logic [7:0] v);
        wdata = v;
        wr = 1'b1;
        step(1);
        wr = 1'b0;
    endtask
    task automatic pulse_wtick(input int c);
        repeat (c) begin
            wtick = 1'b1;
            step(1);
            wtick = 1'b0;
            step(1);
        end
    endtask
    task automatic t_rates;
        asel = 1'b0;
        for (int r = 0; r < 8; r++) begin
            rate = r[2:0];
            write(8'h00);
            wait_change(n);
            wait_change(n);
            check("ratio", n, 4 << (r + 1));
        end
        asel = 1'b1;
        write(8'h00);
        wait_change(n);
        wait_change(n);
        check("ratio undivided", n, 4);
    endtask
    task automatic t_write_clears;
        asel = 1'b0;
        rate = 3'h7;
        write(8'h00);
        step(600);
        write(8'h10);
        wait_change(n);
        check("half period after write", n > 500 && n < 530, 1);
    endtask
    task automatic t_overflow;
        asel = 1'b1;
        ie = 1'b1;
        write(8'hFF);
        wait_change(n);
        check("wrap", cnt, 8'h00);
        check("flag", flag, 1'b1);
        check("irq no global", irq, 1'b0);
        global_irq_enable = 1'b1;
        step(1);
        check("irq", irq, 1'b1);
        ie = 1'b0;
        step(1);
        check("irq masked", irq, 1'b0);
        step(8);
        check("flag sticky", flag, 1'b1);
        fclr = 1'b1;
        step(1);
        fclr = 1'b0;
        check("flag cleared", flag, 1'b0);
    endtask
    task automatic t_sleep_counter;
        sleep = 1'b1;
        step(2);
        n = cnt;
        step(40);
        check("frozen", cnt, n);
        sleep = 1'b0;
        cmode = 1'b1;
        write(8'h00);
        edges = 8'h05;
        go = 1'b1;
        step(1);
        go = 1'b0;
        step(120);
        check("external edges", cnt, 8'h05);
        cmode = 1'b0;
    endtask
    task automatic t_watchdog;
        asel = 1'b0;
        k = 0;
        pulse_wtick(4);
        check("no watchdog tick", k, 0);
        asel = 1'b1;
        rate = 3'h0;
        wclr = 1'b1;
        #1 check("watchdog clear", wcout, 1'b1);
        step(1);
        wclr = 1'b0;
        k = 0;
        pulse_wtick(4);
        step(2);
        check("watchdog ticks", k, 2);
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        step(10);
        rst_n_in = 1'b1;
        check("reset count", {cnt, flag, irq}, 10'h000);
        t_rates;
        t_write_clears;
        t_overflow;
        t_sleep_counter;
        t_watchdog;
        conclude;
    end
    initial begin
        repeat (20000) @(posedge core_clk_in);
        err_total++;
        conclude;
    end
endmodule
